/* File: rtl/qssrq_pkg.sv */
// Constants and types shared by the questionable status and service request logic.
// Functional notes
// - Condition query returns the live questionable condition bits, each following its input.
// - Event bit sets on a rising condition bit and stays set until it is read or cleared.
// - Reading the event register returns its value and clears it in that access.
// - Event and condition read as 16-bit values from 0 to 32767.
// - Condition bit 0 is high while the supply monitor reports a fault.
// - Condition bit 3 is high while a power measurement error is flagged.
// - Condition bit 4 is high when sensor drift exceeds 4C since autocal.
// - Condition bit 8 is high while the sensor needs calibration or zeroing.
// - Questionable enable mask is written 0 to 32767, stored and read back.
// - Service request rises when a questionable bit is true and enabled.
// - A status condition with its mask bit clear never raises a request; the code raises one from status byte bit 3 whatever srq_enable_i bit 3 holds.
// - Each status byte summary bit is the OR of its register's enabled bits.
// - Clear status resets events, status byte, standard events, queue and measurement.
// - Standard event enable mask is written 0 to 255, held and reported.
// - Standard events request service only while status byte bit 5 is enabled.
// - Querying the standard event register returns its value and then clears it.
// - Standard event bits: 0 complete, 3/4/5 errors, 7 power-on.
package qssrq_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int QS_W  = 16;
    localparam int SE_W  = 8;
    localparam int STB_W = 8;
    localparam int DRIFT_W = 8;

    // ****************************************************************
    // Questionable condition bit positions
    // ****************************************************************
    localparam int QB_VOLTAGE     = 0;
    localparam int QB_POWER       = 3;
    localparam int QB_TEMPERATURE = 4;
    localparam int QB_CALIBRATION = 8;
    localparam int QB_SUMMARY     = 13;
    localparam int QB_CMD_WARNING = 14;

    // Bits that may ever be nonzero in the questionable structure.
    localparam logic [QS_W-1:0] QS_USED_MASK = 16'h6119;
    // Writable range of the questionable enable mask, 0 to 32767.
    localparam logic [QS_W-1:0] QS_ENABLE_MASK = 16'h7FFF;

    // ****************************************************************
    // Standard event bit positions
    // ****************************************************************
    localparam int SB_OP_COMPLETE = 0;
    localparam int SB_DEVICE_ERR  = 3;
    localparam int SB_EXEC_ERR    = 4;
    localparam int SB_CMD_ERR     = 5;
    localparam int SB_POWER_ON    = 7;

    // ****************************************************************
    // Status byte bit positions
    // ****************************************************************
    localparam int STB_QUES_SUM = 3;
    localparam int STB_ESB      = 5;
    localparam int STB_RQS      = 6;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [QS_W-1:0]  QS_RESET    = 16'h0000;
    localparam logic [SE_W-1:0]  SE_MASK_RST = 8'h00;
    // Power-on flag is set when the block comes out of reset.
    localparam logic [SE_W-1:0]  SE_EVT_RST  = 8'h80;
    localparam logic [STB_W-1:0] STB_RESET   = 8'h00;

    // ****************************************************************
    // Drift threshold: code is in quarter degrees C.
    // ****************************************************************
    localparam int DRIFT_LIMIT_C    = 4;
    localparam int DRIFT_LSB_PER_C  = 4;
    localparam logic [DRIFT_W-1:0] DRIFT_LIMIT_CODE =
        DRIFT_W'(DRIFT_LIMIT_C * DRIFT_LSB_PER_C);

    // ****************************************************************
    // Command port register select
    // ****************************************************************
    typedef enum logic [2:0] {
        QSSRQ_SEL_QCOND   = 3'h0,
        QSSRQ_SEL_QEVENT  = 3'h1,
        QSSRQ_SEL_QENABLE = 3'h2,
        QSSRQ_SEL_SEMASK  = 3'h3,
        QSSRQ_SEL_SEVENT  = 3'h4,
        QSSRQ_SEL_STB     = 3'h5
    } qssrq_sel_t;

endpackage

/* File: rtl/qssrq_sync.sv */
// Two flip-flop synchroniser for a group of independent level inputs.
`timescale 1ns/1ps
module qssrq_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    import qssrq_pkg::*;

    // Each bit is its own level; the group is never read as one word.
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end else begin
                    meta_reg <= async_i[g];
                    sync_reg <= meta_reg;
                end
            end
            assign sync_o[g] = sync_reg;
        end
    endgenerate

endmodule

/* File: rtl/qssrq_top.sv */
// Questionable status, standard event and service request logic.
`timescale 1ns/1ps
module qssrq_top (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Fault pins from outside the clock domain.
    input  wire logic                          supply_fault_i,
    input  wire logic                          power_error_i,
    input  wire logic                          cal_needed_i,
    input  wire logic                          instr_summary_i,
    input  wire logic                          cmd_warning_i,
    // Drift code from the on-chip calibration engine, quarter degrees C.
    input  wire logic [qssrq_pkg::DRIFT_W-1:0] drift_code_i,
    // One-cycle event pulses from same-clock logic.
    input  wire logic                          op_complete_i,
    input  wire logic                          device_err_i,
    input  wire logic                          exec_err_i,
    input  wire logic                          cmd_err_i,
    // Service request enable register held elsewhere.
    input  wire logic [qssrq_pkg::STB_W-1:0]   srq_enable_i,
    // Clear status command.
    input  wire logic                          clear_status_i,
    // Command port.
    input  wire logic                          cmd_valid_i,
    input  wire logic                          cmd_write_i,
    input  wire qssrq_pkg::qssrq_sel_t         cmd_sel_i,
    input  wire logic [qssrq_pkg::QS_W-1:0]    cmd_wdata_i,
    output logic                               rsp_valid_o,
    output logic      [qssrq_pkg::QS_W-1:0]    rsp_data_o,
    // Status outputs.
    output logic      [qssrq_pkg::STB_W-1:0]   status_byte_o,
    output logic                               srq_o,
    output logic                               clear_others_o
);
    import qssrq_pkg::*;

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    localparam int N_PINS = 5;

    logic [N_PINS-1:0] pins_async;
    logic [N_PINS-1:0] pins_sync;

    assign pins_async = {cmd_warning_i, instr_summary_i, cal_needed_i,
                         power_error_i, supply_fault_i};

    qssrq_sync #(
        .W (N_PINS)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pins_async),
        .sync_o  (pins_sync)
    );

    logic supply_fault_s;
    logic power_error_s;
    logic cal_needed_s;
    logic instr_summary_s;
    logic cmd_warning_s;

    assign supply_fault_s  = pins_sync[0];
    assign power_error_s   = pins_sync[1];
    assign cal_needed_s    = pins_sync[2];
    assign instr_summary_s = pins_sync[3];
    assign cmd_warning_s   = pins_sync[4];

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Latched event update: a set in the same cycle as a clear wins,
    // so a condition edge that lands on the read is reported next time.
    function automatic logic [QS_W-1:0] latch_update(
        input logic [QS_W-1:0] cur,
        input logic [QS_W-1:0] set,
        input logic            clr
    );
        logic [QS_W-1:0] kept;
        kept = clr ? '0 : cur;
        return kept | set;
    endfunction

    // ****************************************************************
    // Command decode
    // ****************************************************************
    logic cmd_rd;
    logic cmd_wr;

    assign cmd_rd = cmd_valid_i && !cmd_write_i;
    assign cmd_wr = cmd_valid_i && cmd_write_i;

    // ****************************************************************
    // Status state: next values
    // ****************************************************************
    logic [QS_W-1:0]  qcond_reg;
    logic [QS_W-1:0]  qcond_next;
    logic [QS_W-1:0]  qevent_reg;
    logic [QS_W-1:0]  qevent_next;
    logic [QS_W-1:0]  qenable_reg;
    logic [QS_W-1:0]  qenable_next;
    logic [SE_W-1:0]  sevent_reg;
    logic [SE_W-1:0]  sevent_next;
    logic [SE_W-1:0]  semask_reg;
    logic [SE_W-1:0]  semask_next;
    logic [STB_W-1:0] stb_reg;
    logic [STB_W-1:0] stb_next;
    logic             srq_reg;
    logic             srq_next;
    logic             clr_oth_reg;
    logic             clr_oth_next;
    logic             rsp_valid_reg;
    logic             rsp_valid_next;
    logic [QS_W-1:0]  rsp_data_reg;
    logic [QS_W-1:0]  rsp_data_next;

    always_comb begin
        logic [QS_W-1:0] q_rise;
        logic [QS_W-1:0] s_set;
        logic [QS_W-1:0] s_wide;
        logic            q_clr;
        logic            s_clr;
        logic            q_sum;
        logic            esb;
        q_rise = '0;
        s_set  = '0;
        s_wide = '0;
        q_clr  = 1'b0;
        s_clr  = 1'b0;
        q_sum  = 1'b0;
        esb    = 1'b0;

        // Live condition word; unused positions stay zero.
        qcond_next                 = QS_RESET;
        qcond_next[QB_VOLTAGE]     = supply_fault_s;
        qcond_next[QB_POWER]       = power_error_s;
        qcond_next[QB_TEMPERATURE] = drift_code_i > DRIFT_LIMIT_CODE;
        qcond_next[QB_CALIBRATION] = cal_needed_s;
        qcond_next[QB_SUMMARY]     = instr_summary_s;
        qcond_next[QB_CMD_WARNING] = cmd_warning_s;
        qcond_next                 = qcond_next & QS_USED_MASK;

        // Rising condition bits latch into the event register.
        q_rise      = qcond_next & ~qcond_reg;
        q_clr       = clear_status_i || (cmd_rd && cmd_sel_i == QSSRQ_SEL_QEVENT);
        qevent_next = latch_update(qevent_reg, q_rise, q_clr);

        // Standard event register.
        s_set                 = '0;
        s_set[SB_OP_COMPLETE] = op_complete_i;
        s_set[SB_DEVICE_ERR]  = device_err_i;
        s_set[SB_EXEC_ERR]    = exec_err_i;
        s_set[SB_CMD_ERR]     = cmd_err_i;
        s_clr  = clear_status_i || (cmd_rd && cmd_sel_i == QSSRQ_SEL_SEVENT);
        s_wide = latch_update({8'h00, sevent_reg}, s_set, s_clr);
        sevent_next = s_wide[SE_W-1:0];

        // Masks: stored as written, cut to their legal range.
        qenable_next = qenable_reg;
        semask_next  = semask_reg;
        if (cmd_wr && cmd_sel_i == QSSRQ_SEL_QENABLE) begin
            qenable_next = cmd_wdata_i & QS_ENABLE_MASK;
        end
        if (cmd_wr && cmd_sel_i == QSSRQ_SEL_SEMASK) begin
            semask_next = cmd_wdata_i[SE_W-1:0];
        end

        // Summaries use the updated event words so a clear takes effect
        // in the same cycle as the registers it clears.
        q_sum = |(qevent_next & qenable_next);
        esb   = |(sevent_next & semask_next);

        stb_next               = STB_RESET;
        stb_next[STB_QUES_SUM] = q_sum;
        stb_next[STB_ESB]      = esb;

        // A masked-off condition contributes nothing to either summary.
        srq_next = q_sum || (esb && srq_enable_i[STB_ESB]);
        stb_next[STB_RQS] = srq_next;

        // Operation status, error queue and measurement are cleared by
        // their owners on this pulse.
        clr_oth_next = clear_status_i;
    end

    // ****************************************************************
    // Read response: next values
    // ****************************************************************
    always_comb begin
        rsp_valid_next = cmd_rd;
        rsp_data_next  = '0;
        if (cmd_rd) begin
            unique case (cmd_sel_i)
                QSSRQ_SEL_QCOND: begin
                    rsp_data_next = qcond_reg;
                end
                QSSRQ_SEL_QEVENT: begin
                    rsp_data_next = qevent_reg;
                end
                QSSRQ_SEL_QENABLE: begin
                    rsp_data_next = qenable_reg;
                end
                QSSRQ_SEL_SEMASK: begin
                    rsp_data_next = {8'h00, semask_reg};
                end
                QSSRQ_SEL_SEVENT: begin
                    rsp_data_next = {8'h00, sevent_reg};
                end
                QSSRQ_SEL_STB: begin
                    rsp_data_next = {8'h00, stb_reg};
                end
                default: begin
                    rsp_data_next = '0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            qcond_reg     <= QS_RESET;
            qevent_reg    <= QS_RESET;
            qenable_reg   <= QS_RESET;
            sevent_reg    <= SE_EVT_RST;
            semask_reg    <= SE_MASK_RST;
            stb_reg       <= STB_RESET;
            srq_reg       <= 1'b0;
            clr_oth_reg   <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg  <= '0;
        end else begin
            qcond_reg     <= qcond_next;
            qevent_reg    <= qevent_next;
            qenable_reg   <= qenable_next;
            sevent_reg    <= sevent_next;
            semask_reg    <= semask_next;
            stb_reg       <= stb_next;
            srq_reg       <= srq_next;
            clr_oth_reg   <= clr_oth_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg  <= rsp_data_next;
        end
    end

    assign rsp_valid_o    = rsp_valid_reg;
    assign rsp_data_o     = rsp_data_reg;
    assign status_byte_o  = stb_reg;
    assign srq_o          = srq_reg;
    assign clear_others_o = clr_oth_reg;

endmodule

/* File: verif/qssrq_props.sv */
// Checker of the questionable status and service request ports.
`timescale 1ns/1ps
module qssrq_props (
    input wire logic                        clk_i,
    input wire logic                        rst_i,
    input wire logic                        clear_status_i,
    input wire logic                        cmd_valid_i,
    input wire logic                        cmd_write_i,
    input wire qssrq_pkg::qssrq_sel_t       cmd_sel_i,
    input wire logic [qssrq_pkg::QS_W-1:0]  cmd_wdata_i,
    input wire logic [qssrq_pkg::STB_W-1:0] srq_enable_i,
    input wire logic                        rsp_valid_o,
    input wire logic [qssrq_pkg::QS_W-1:0]  rsp_data_o,
    input wire logic [qssrq_pkg::STB_W-1:0] status_byte_o,
    input wire logic                        srq_o,
    input wire logic                        clear_others_o
);
    import qssrq_pkg::*;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire rd_now  = cmd_valid_i && !cmd_write_i;
    wire wr_now  = cmd_valid_i && cmd_write_i;
    rsp_timing_a: assert property (rsp_valid_o == $past(rd_now))
        else $error("read answer not one cycle after the read");
    rsp_range_a: assert property (rsp_valid_o |-> !rsp_data_o[15])
        else $error("read value above 32767");
    cond_unused_a: assert property (rd_now && cmd_sel_i == QSSRQ_SEL_QCOND |=>
        (rsp_data_o & ~QS_USED_MASK) == 16'h0000) else $error("unused condition bit set");
    stb_unused_a: assert property (status_byte_o[2:0] == 3'h0 && !status_byte_o[4] &&
        !status_byte_o[7]) else $error("unused status byte bit set");
    rqs_mirror_a: assert property (status_byte_o[STB_RQS] == srq_o)
        else $error("request bit differs from service request");
    srq_source_a: assert property (srq_o == (status_byte_o[STB_QUES_SUM] ||
        (status_byte_o[STB_ESB] && $past(srq_enable_i[STB_ESB]))))
        else $error("service request not from enabled summaries");
    clear_pulse_a: assert property (clear_others_o == $past(clear_status_i))
        else $error("clear pulse wrong");
    qen_back_a: assert property (wr_now && cmd_sel_i == QSSRQ_SEL_QENABLE ##1
        rd_now && cmd_sel_i == QSSRQ_SEL_QENABLE |=>
        rsp_data_o == ($past(cmd_wdata_i, 2) & QS_ENABLE_MASK)) else $error("enable readback");
    sem_back_a: assert property (wr_now && cmd_sel_i == QSSRQ_SEL_SEMASK ##1
        rd_now && cmd_sel_i == QSSRQ_SEL_SEMASK |=>
        rsp_data_o == ($past(cmd_wdata_i, 2) & 16'h00FF)) else $error("event mask readback");
    cover property (srq_o);
    cover property (clear_others_o);
    cover property (wr_now ##1 rd_now);
endmodule
bind qssrq_top qssrq_props u_qssrq_props (.clk_i, .rst_i, .clear_status_i, .cmd_valid_i,
    .cmd_write_i, .cmd_sel_i, .cmd_wdata_i, .srq_enable_i, .rsp_valid_o, .rsp_data_o,
    .status_byte_o, .srq_o, .clear_others_o);

/* File: verif/qssrq_ctrl_model.sv */
// Remote controller model that issues status commands to the block.
`timescale 1ns/1ps
module qssrq_ctrl_model (
    input  wire logic                       clk_i,
    input  wire logic                       rsp_valid_i,
    input  wire logic [qssrq_pkg::QS_W-1:0] rsp_data_i,
    output logic                            cmd_valid_o,
    output logic                            cmd_write_o,
    output qssrq_pkg::qssrq_sel_t           cmd_sel_o,
    output logic      [qssrq_pkg::QS_W-1:0] cmd_wdata_o
);
    import qssrq_pkg::*;
    // ****************************************************************
    // Command issue
    // ****************************************************************
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_sel_o   = QSSRQ_SEL_QCOND;
        cmd_wdata_o = 16'h0000;
    end
    task automatic issue(input logic w, input qssrq_sel_t s, input logic [QS_W-1:0] d);
        cmd_valid_o = 1'b1;
        cmd_write_o = w;
        cmd_sel_o   = s;
        cmd_wdata_o = d;
        @(posedge clk_i);
        #1;
    endtask
    // Idle qualifiers flip so that a stale value is never mistaken for a live one.
    task automatic release_bus(output logic [QS_W-1:0] q, output logic v);
        cmd_valid_o = 1'b0;
        cmd_write_o = ~cmd_write_o;
        cmd_sel_o   = qssrq_sel_t'(~cmd_sel_o);
        cmd_wdata_o = ~cmd_wdata_o;
        q = rsp_data_i;
        v = rsp_valid_i;
    endtask
    task automatic xfer(input logic w, input qssrq_sel_t s, input logic [QS_W-1:0] d,
                        output logic [QS_W-1:0] q, output logic v);
        @(posedge clk_i);
        #1;
        issue(w, s, d);
        release_bus(q, v);
    endtask
    task automatic wr_rd(input qssrq_sel_t s, input logic [QS_W-1:0] d,
                         output logic [QS_W-1:0] q, output logic v);
        @(posedge clk_i);
        #1;
        issue(1'b1, s, d);
        issue(1'b0, s, d);
        release_bus(q, v);
    endtask
endmodule

/* File: verif/tb_qssrq_top.sv */
// Self-checking bench of the questionable status and service request logic.
`timescale 1ns/1ps
module tb_qssrq_top;
    import qssrq_pkg::*;
    logic             clk_i = 1'b0;
    logic             rst_i;
    logic [4:0]       pins;
    logic [7:0]       drift;
    logic [3:0]       evt;
    logic [7:0]       sre;
    logic             clr;
    logic             cmd_valid;
    logic             cmd_write;
    qssrq_sel_t       cmd_sel;
    logic [QS_W-1:0]  cmd_wdata;
    logic             rsp_valid;
    logic [QS_W-1:0]  rsp_data;
    logic [7:0]       stb;
    logic             srq;
    logic             clr_oth;
    logic [QS_W-1:0]  q;
    logic [QS_W-1:0]  d;
    logic             v;
    int               mismatches = 0;
    int               cmp_count = 0;
    int               seed;
    qssrq_top u_qssrq_top (.clk_i(clk_i), .rst_i(rst_i), .supply_fault_i(pins[0]),
        .power_error_i(pins[1]), .cal_needed_i(pins[2]), .instr_summary_i(pins[3]),
        .cmd_warning_i(pins[4]), .drift_code_i(drift), .op_complete_i(evt[0]),
        .device_err_i(evt[1]), .exec_err_i(evt[2]), .cmd_err_i(evt[3]),
        .srq_enable_i(sre), .clear_status_i(clr), .cmd_valid_i(cmd_valid),
        .cmd_write_i(cmd_write), .cmd_sel_i(cmd_sel), .cmd_wdata_i(cmd_wdata),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .status_byte_o(stb),
        .srq_o(srq), .clear_others_o(clr_oth));
    qssrq_ctrl_model u_qssrq_ctrl_model (.clk_i(clk_i), .rsp_valid_i(rsp_valid),
        .rsp_data_i(rsp_data), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
        .cmd_sel_o(cmd_sel), .cmd_wdata_o(cmd_wdata));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    function automatic logic [QS_W-1:0] exp_cond(input logic [4:0] p, input logic [7:0] dc);
        exp_cond = QS_RESET;
        exp_cond[QB_VOLTAGE] = p[0];
        exp_cond[QB_POWER] = p[1];
        exp_cond[QB_TEMPERATURE] = dc > DRIFT_LIMIT_CODE;
        exp_cond[QB_CALIBRATION] = p[2];
        exp_cond[QB_SUMMARY] = p[3];
        exp_cond[QB_CMD_WARNING] = p[4];
    endfunction
    task automatic check(input logic [QS_W-1:0] seen, input logic [QS_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic rd(input qssrq_sel_t s, input logic [QS_W-1:0] exp);
        u_qssrq_ctrl_model.xfer(1'b0, s, 16'h0000, q, v);
        check({15'h0000, v}, 16'h0001);
        check(q, exp);
    endtask
    task automatic wr(input qssrq_sel_t s, input logic [QS_W-1:0] dv);
        u_qssrq_ctrl_model.xfer(1'b1, s, dv, q, v);
    endtask
    task automatic pulse_clear();
        clr = 1'b1;
        wait_n(1);
        clr = 1'b0;
    endtask
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        test_done();
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        seed = 42449;
        {rst_i, pins, drift, evt, sre, clr} = {1'b1, 5'h00, 8'h00, 4'h0, 8'h00, 1'b0};
        repeat (6) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        rd(QSSRQ_SEL_SEVENT, 16'h0080);
        rd(QSSRQ_SEL_SEVENT, 16'h0000);
        rd(QSSRQ_SEL_QENABLE, QS_RESET);
        rd(QSSRQ_SEL_SEMASK, 16'h0000);
        rd(qssrq_sel_t'(3'h6), 16'h0000);
        drift = DRIFT_LIMIT_CODE;
        wait_n(4);
        rd(QSSRQ_SEL_QCOND, 16'h0000);
        drift = DRIFT_LIMIT_CODE + 8'h01;
        wait_n(4);
        rd(QSSRQ_SEL_QCOND, 16'h0010);
        for (int i = 0; i < 5; i++) begin
            pins = 5'h01 << i;
            wait_n(4);
            rd(QSSRQ_SEL_QCOND, exp_cond(pins, drift));
        end
        {pins, drift} = 13'h0000;
        wait_n(4);
        rd(QSSRQ_SEL_QCOND, 16'h0000);
        rd(QSSRQ_SEL_QEVENT, QS_USED_MASK);
        rd(QSSRQ_SEL_QEVENT, 16'h0000);
        // Raw write data goes in so that the cut to the legal range is exercised.
        for (int i = 0; i < 16; i++) begin
            pins = 5'($random(seed));
            drift = 8'($random(seed));
            d = (i == 0) ? 16'hFFFF : 16'($random(seed));
            u_qssrq_ctrl_model.wr_rd(QSSRQ_SEL_QENABLE, d, q, v);
            check(q, d & QS_ENABLE_MASK);
            u_qssrq_ctrl_model.wr_rd(QSSRQ_SEL_SEMASK, d, q, v);
            check(q, d & 16'h00FF);
            wait_n(2);
            rd(QSSRQ_SEL_QCOND, exp_cond(pins, drift));
        end
        pulse_clear();
        check({15'h0000, clr_oth}, 16'h0001);
        wait_n(1);
        check({8'h00, stb}, 16'h0000);
        rd(QSSRQ_SEL_QEVENT, 16'h0000);
        rd(QSSRQ_SEL_SEVENT, 16'h0000);
        {pins, drift} = 13'h0000;
        wr(QSSRQ_SEL_QENABLE, 16'h0000);
        wait_n(4);
        pins = 5'h01;
        wait_n(4);
        check({8'h00, stb}, 16'h0000);
        check({15'h0000, srq}, 16'h0000);
        wr(QSSRQ_SEL_QENABLE, 16'h0001);
        wait_n(1);
        check({8'h00, stb}, 16'h0048);
        pulse_clear();
        wait_n(1);
        check({8'h00, stb}, 16'h0000);
        wr(QSSRQ_SEL_SEMASK, 16'h0001);
        evt = 4'h1;
        wait_n(1);
        evt = 4'h0;
        wait_n(1);
        check({8'h00, stb}, 16'h0020);
        sre = 8'h20;
        wait_n(2);
        check({8'h00, stb}, 16'h0060);
        check({15'h0000, srq}, 16'h0001);
        rd(QSSRQ_SEL_STB, 16'h0060);
        rd(QSSRQ_SEL_SEVENT, 16'h0001);
        wait_n(1);
        check({8'h00, stb}, 16'h0000);
        for (int i = 1; i < 4; i++) begin
            evt = 4'h1 << i;
            wait_n(1);
            evt = 4'h0;
            rd(QSSRQ_SEL_SEVENT, 16'h0001 << (i + 2));
        end
        // An event landing on the clear pulse must survive it.
        evt = 4'h1;
        pulse_clear();
        evt = 4'h0;
        rd(QSSRQ_SEL_SEVENT, 16'h0001);
        // A second reset in mid-run brings back the power-on flag and clears the masks.
        rst_i = 1'b1;
        wait_n(2);
        rst_i = 1'b0;
        rd(QSSRQ_SEL_SEVENT, 16'h0080);
        rd(QSSRQ_SEL_SEMASK, 16'h0000);
        rd(QSSRQ_SEL_STB, 16'h0000);
        test_done();
    end
endmodule
